// ==== rtl/uart_transmit_format_control.sv ====
`include "uart_tx_defs.svh"
// Overview of operation
// - Reset format is eight data, no parity, one stop.
// - Frame is start, 8 or 9 bits, two_stop_select.
// - LSB first, rate from 8-bit divisor.
// - One shared format and baud for both directions.
// - Format bits pick length, parity, parity sense, two_stop_select.
// - Parity replaces the last data position.
// - Enabled and idle, transmit pin sits high.
// - Unit off floats transmit and receive pins.
// - Unit off empties and discards buffered data.
// - Unit off clears transmit and receive enables and break, sets empty and idle flags.
// - Unit off aborts at once; re-enable keeps config.
// - Ninth bit comes from the ninth-bit control field.
// - Shifter reloads only after two_stop_select, if data waits.
// - Start needs transmit on and data, not a baud tick.
// - Transmit off aborts frame and floats pin.
// - Idle write with transmit on goes straight to shifter, flag set.
// - Holding writes ignored while empty flag is low.
// - Status access then holding write clears flags.
// - Empty flag set when holding empty; irq gated.
// - Idle flag set after two_stop_select or break frame.
// - Break sends start plus zeros in thirteens.
// - Break ends with stop bits; no irq for break.
// - Baud is clock over 64 or 16 times N+1.
module uart_transmit_format_control
  import uart_tx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic tx_out,
  output logic tx_oe,
  output logic rx_oe_enable,
  output logic irq_out
);

  // Registered state and its next value.
  uart_state_t state_ff;
  uart_state_t nxt_state;

  // Computes the parity bit over the data bits that will be sent.
  function automatic logic parity_of(input logic [8:0] bits, input logic nine,
                                     input logic odd);
    logic p;
    p = nine ? ^bits[7:0] : ^bits[6:0];
    parity_of = p ^ odd;
  endfunction

  // Builds the shifter image from data, ninth bit and the format fields.
  function automatic logic [8:0] frame_of(input logic [7:0] data, input logic ninth,
                                          input logic [7:0] lc1);
    logic [8:0] img;
    logic nine;
    img = {ninth, data};
    nine = lc1[`LC1_NINE_BIT];
    if (lc1[`LC1_PARITY_ON]) begin
      // Parity takes the top data position of the chosen length.
      if (nine) begin
        img[8] = parity_of(img, 1'b1, lc1[`LC1_PARITY_ODD]);
      end else begin
        img[7] = parity_of(img, 1'b0, lc1[`LC1_PARITY_ODD]);
      end
    end
    frame_of = img;
  endfunction

  // Combinational next-state for the whole block.
  always_comb begin
    logic unit_on;
    logic tx_on;
    logic tick;
    logic [5:0] presc_max;
    logic [3:0] data_bits;
    logic holding_write;
    logic [7:0] lc1_w;
    logic [7:0] lc2_w;
    unit_on = 1'b0;
    tx_on = 1'b0;
    tick = 1'b0;
    presc_max = 6'd0;
    data_bits = 4'd0;
    holding_write = 1'b0;
    lc1_w = 8'h00;
    lc2_w = 8'h00;
    nxt_state = state_ff;
    nxt_state.read_data = 8'h00;

    // Register writes; unit-off side effects follow below.
    if (reg_write) begin
      unique case (reg_addr)
        `ADDR_LINE_CONTROL_ONE: begin
          nxt_state.line_control_one = reg_wdata;
        end
        `ADDR_LINE_CONTROL_TWO: begin
          nxt_state.line_control_two = reg_wdata;
        end
        `ADDR_BAUD_DIVISOR: begin
          nxt_state.baud_divisor = reg_wdata;
        end
        `ADDR_TX_HOLDING: begin
          // Only a write that follows a status access while empty is taken.
          if (state_ff.transmit_buffer_empty_flag && state_ff.status_accessed &&
              state_ff.line_control_one[`LC1_SERIAL_UNIT_ON]) begin
            holding_write = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads; data stand in the following cycle.
    if (reg_read) begin
      unique case (reg_addr)
        `ADDR_LINE_CONTROL_ONE: nxt_state.read_data = state_ff.line_control_one;
        `ADDR_LINE_CONTROL_TWO: nxt_state.read_data = state_ff.line_control_two;
        `ADDR_BAUD_DIVISOR: nxt_state.read_data = state_ff.baud_divisor;
        `ADDR_LINE_STATUS: begin
          nxt_state.read_data = {4'h0, (state_ff.state != ST_IDLE), 1'b1,
                                 state_ff.transmit_idle_flag,
                                 state_ff.transmit_buffer_empty_flag};
        end
        default: nxt_state.read_data = 8'h00;
      endcase
    end

    // A status access arms the flag clear sequence.
    if ((reg_read || reg_write) && reg_addr == `ADDR_LINE_STATUS) begin
      nxt_state.status_accessed = 1'b1;
    end else if (holding_write) begin
      nxt_state.status_accessed = 1'b0;
    end

    if (holding_write) begin
      // The sequence clears both flags; the shifter path may set one again.
      nxt_state.transmit_holding_register = reg_wdata;
      nxt_state.holding_ninth = state_ff.line_control_one[`LC1_TX_NINTH];
      nxt_state.holding_full = 1'b1;
      nxt_state.transmit_buffer_empty_flag = 1'b0;
      nxt_state.transmit_idle_flag = 1'b0;
    end

    unit_on = nxt_state.line_control_one[`LC1_SERIAL_UNIT_ON];
    tx_on = unit_on && nxt_state.line_control_two[`LC2_TRANSMIT_ON];

    // Baud generator: prescale of 64 or 16, then divisor N+1.
    presc_max = state_ff.line_control_two[`LC2_BAUD_HIGH] ? `PRESCALE_HIGH : `PRESCALE_LOW;
    if (state_ff.state == ST_IDLE) begin
      nxt_state.prescale_count = 6'd0;
      nxt_state.divisor_count = 8'd0;
    end else if (state_ff.prescale_count >= presc_max) begin
      nxt_state.prescale_count = 6'd0;
      if (state_ff.divisor_count >= state_ff.baud_divisor) begin
        nxt_state.divisor_count = 8'd0;
        tick = 1'b1;
      end else begin
        nxt_state.divisor_count = state_ff.divisor_count + 8'd1;
      end
    end else begin
      nxt_state.prescale_count = state_ff.prescale_count + 6'd1;
    end

    // Data positions: 8 or 9 including any parity bit.
    data_bits = state_ff.line_control_one[`LC1_NINE_BIT] ? 4'd9 : 4'd8;

    // Transmit sequencer.
    unique case (state_ff.state)
      ST_IDLE: begin
        nxt_state.tx_level = 1'b1;
        if (tx_on && nxt_state.line_control_two[`LC2_SEND_BREAK]) begin
          // Break frame: start then zero bits in chunks of thirteen.
          nxt_state.state = ST_START;
          nxt_state.break_open = 1'b1;
        end else if (tx_on && nxt_state.holding_full) begin
          // Empty shifter takes new data at once, freeing the holding register.
          nxt_state.transmit_shifter = frame_of(nxt_state.transmit_holding_register,
                                                nxt_state.holding_ninth,
                                                nxt_state.line_control_one);
          nxt_state.holding_full = 1'b0;
          nxt_state.transmit_buffer_empty_flag = 1'b1;
          nxt_state.break_open = 1'b0;
          nxt_state.state = ST_START;
        end
      end
      ST_START: begin
        nxt_state.tx_level = 1'b0;
        if (tick) begin
          nxt_state.bit_count = 4'd0;
          nxt_state.state = state_ff.break_open ? ST_BREAK : ST_DATA;
        end
      end
      ST_DATA: begin
        // Least significant bit first.
        nxt_state.tx_level = state_ff.transmit_shifter[0];
        if (tick) begin
          nxt_state.transmit_shifter = {1'b0, state_ff.transmit_shifter[8:1]};
          if (state_ff.bit_count == data_bits - 4'd1) begin
            nxt_state.state = ST_STOP;
            nxt_state.stop_count = 1'b0;
          end else begin
            nxt_state.bit_count = state_ff.bit_count + 4'd1;
          end
        end
      end
      ST_BREAK: begin
        nxt_state.tx_level = 1'b0;
        if (tick) begin
          if (state_ff.bit_count == `BREAK_CHUNK - 4'd1) begin
            nxt_state.bit_count = 4'd0;
            // Another chunk while break stays set, else two_stop_select follow.
            if (!state_ff.line_control_two[`LC2_SEND_BREAK]) begin
              nxt_state.state = ST_STOP;
              nxt_state.stop_count = 1'b0;
            end
          end else begin
            nxt_state.bit_count = state_ff.bit_count + 4'd1;
          end
        end
      end
      ST_STOP: begin
        nxt_state.tx_level = 1'b1;
        if (tick) begin
          if (state_ff.line_control_one[`LC1_TWO_STOP] && !state_ff.stop_count) begin
            nxt_state.stop_count = 1'b1;
          end else begin
            // Frame done; reload happens from idle only now.
            nxt_state.state = ST_IDLE;
            nxt_state.transmit_idle_flag = 1'b1;
            nxt_state.break_open = 1'b0;
          end
        end
      end
      default: begin
        nxt_state.state = ST_IDLE;
      end
    endcase

    // Transmit off aborts and resets the transmitter.
    if (!tx_on) begin
      nxt_state.state = ST_IDLE;
      nxt_state.tx_level = 1'b1;
      nxt_state.bit_count = 4'd0;
      nxt_state.break_open = 1'b0;
    end

    // Unit off: abort, discard buffer, clear/set flags, keep config.
    if (!unit_on) begin
      lc2_w = nxt_state.line_control_two;
      lc2_w[`LC2_TRANSMIT_ON] = 1'b0;
      lc2_w[`LC2_RECEIVE_ON] = 1'b0;
      lc2_w[`LC2_SEND_BREAK] = 1'b0;
      nxt_state.line_control_two = lc2_w;
      nxt_state.holding_full = 1'b0;
      nxt_state.transmit_buffer_empty_flag = 1'b1;
      nxt_state.transmit_idle_flag = 1'b1;
      nxt_state.status_accessed = 1'b0;
    end
    lc1_w = nxt_state.line_control_one;

    // Pin drive: float unless both enables.
    nxt_state.tx_enable = lc1_w[`LC1_SERIAL_UNIT_ON] &&
                          nxt_state.line_control_two[`LC2_TRANSMIT_ON];
    nxt_state.rx_enable = lc1_w[`LC1_SERIAL_UNIT_ON] &&
                          nxt_state.line_control_two[`LC2_RECEIVE_ON];

    // Empty interrupt; break frames raise none since the flag stays.
    nxt_state.irq = nxt_state.transmit_buffer_empty_flag &&
                    nxt_state.line_control_two[`LC2_TX_EMPTY_IRQ_EN] &&
                    lc1_w[`LC1_SERIAL_UNIT_ON];
  end

  // State register; reset gives 8-N-1 and a released unit.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
      state_ff.line_control_one <= `RST_LINE_CONTROL_ONE;
      state_ff.line_control_two <= `RST_LINE_CONTROL_TWO;
      state_ff.baud_divisor <= `RST_BAUD_DIVISOR;
      state_ff.transmit_buffer_empty_flag <= 1'b1;
      state_ff.transmit_idle_flag <= 1'b1;
      state_ff.tx_level <= 1'b1;
      state_ff.state <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs come straight from the state register.
  assign reg_rdata = state_ff.read_data;
  assign tx_out = state_ff.tx_level;
  assign tx_oe = state_ff.tx_enable;
  assign rx_oe_enable = state_ff.rx_enable;
  assign irq_out = state_ff.irq;

endmodule

// ==== rtl/uart_tx_defs.svh ====
`ifndef UART_TX_DEFS_SVH
`define UART_TX_DEFS_SVH

// Register addresses on the plain register port.
`define ADDR_LINE_CONTROL_ONE 3'h0
`define ADDR_LINE_CONTROL_TWO 3'h1
`define ADDR_BAUD_DIVISOR 3'h2
`define ADDR_LINE_STATUS 3'h3
`define ADDR_TX_HOLDING 3'h4

// Field positions in line_control_one.
`define LC1_SERIAL_UNIT_ON 7
`define LC1_NINE_BIT 6
`define LC1_PARITY_ON 5
`define LC1_PARITY_ODD 4
`define LC1_TWO_STOP 3
`define LC1_TX_NINTH 0

// Field positions in line_control_two.
`define LC2_TRANSMIT_ON 7
`define LC2_RECEIVE_ON 6
`define LC2_BAUD_HIGH 5
`define LC2_SEND_BREAK 4
`define LC2_TX_EMPTY_IRQ_EN 3

// Field positions in line_status_register.
`define LS_TX_BUF_EMPTY 0
`define LS_TX_IDLE 1
`define LS_RX_IDLE 2
`define LS_TX_ACTIVE 3

// Reset values.
`define RST_LINE_CONTROL_ONE 8'h00
`define RST_LINE_CONTROL_TWO 8'h00
`define RST_BAUD_DIVISOR 8'h00

// Baud generator prescale counts and break length.
`define PRESCALE_LOW 6'd63
`define PRESCALE_HIGH 6'd15
`define BREAK_CHUNK 4'd13

`endif

// ==== rtl/uart_tx_pkg.sv ====
package uart_tx_pkg;

  // Transmitter sequencing states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_BREAK,
    ST_STOP
  } tx_state_t;

  // Whole state of the block, registered as one unit.
  typedef struct packed {
    logic [7:0] line_control_one;
    logic [7:0] line_control_two;
    logic [7:0] baud_divisor;
    logic [7:0] transmit_holding_register;
    logic holding_ninth;
    logic holding_full;
    logic transmit_buffer_empty_flag;
    logic transmit_idle_flag;
    logic status_accessed;
    logic [8:0] transmit_shifter;
    tx_state_t state;
    logic [3:0] bit_count;
    logic stop_count;
    logic break_open;
    logic [5:0] prescale_count;
    logic [7:0] divisor_count;
    logic tx_level;
    logic tx_enable;
    logic rx_enable;
    logic irq;
    logic [7:0] read_data;
  } uart_state_t;

endpackage

// ==== dv/uart_line_rx.sv ====
// Remote receiver on the transmit line; it decodes each frame it sees.
module uart_line_rx (
  input wire logic clk_sys,
  input wire logic tx_out,
  input wire logic tx_oe,
  input int bit_clks,
  input wire logic [3:0] nbits,
  output logic [8:0] rx_word,
  output logic stop_ok,
  output int frames
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released pin is pulled high, so a floated line reads as idle.
  logic line;
  assign line = tx_oe ? tx_out : 1'b1;
  // Sample mid-bit; a start edge always re-aligns, so drift never piles up.
  initial begin
    rx_word = 9'h000;
    stop_ok = 1'b0;
    frames = 0;
    forever begin
      @(negedge line);
      repeat (bit_clks / 2) @(posedge clk_sys);
      rx_word = 9'h000;
      for (int i = 0; i < nbits; i++) begin
        repeat (bit_clks) @(posedge clk_sys);
        rx_word[i] = line;
      end
      repeat (bit_clks) @(posedge clk_sys);
      stop_ok = line;
      frames++;
    end
  end
endmodule

// ==== dv/uart_tx_chk.sv ====
module uart_tx_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic tx_out,
  input wire logic tx_oe,
  input wire logic rx_oe_enable,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Unit switched off by a control write.
  sequence unit_off_w;
    reg_write && reg_addr == 3'h0 && !reg_wdata[7];
  endsequence
  // Status register read.
  sequence status_rd;
    reg_read && reg_addr == 3'h3;
  endsequence
  unit_off_float_a: assert property (unit_off_w |-> ##[1:2] (!tx_oe && !rx_oe_enable))
    else $error("pins still driven after unit off");
  tx_off_float_a: assert property (reg_write && reg_addr == 3'h1 && !reg_wdata[7] |-> ##[1:2] !tx_oe)
    else $error("transmit pin driven after transmit off");
  rx_pin_off_a: assert property (reg_write && reg_addr == 3'h1 && !reg_wdata[6] |-> ##[1:2] !rx_oe_enable)
    else $error("receive pin active after receive off");
  off_flags_set_a: assert property (unit_off_w ##[1:6] status_rd |=> reg_rdata[1:0] == 2'h3)
    else $error("idle or empty flag clear after unit off");
  rx_idle_seen_a: assert property (status_rd |=> reg_rdata[2])
    else $error("receive idle flag low");
  start_len_a: assert property ($fell(tx_out) |=> (!tx_out || !tx_oe) [*8])
    else $error("start bit too short");
  irq_gate_a: assert property (reg_write && reg_addr == 3'h1 && !reg_wdata[3] |-> ##[1:2] !irq_out)
    else $error("interrupt with enable clear");
  drive_cause_a: assert property ($rose(tx_oe) |-> $past(reg_write) || $past(reg_write, 2) || $past(reg_write, 3))
    else $error("pin drive began without a control write");
  status_cov: cover property (status_rd);
endmodule

bind uart_transmit_format_control uart_tx_chk uart_tx_chk_inst (.clk_sys(clk_sys), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .tx_out(tx_out), .tx_oe(tx_oe), .rx_oe_enable(rx_oe_enable),
  .irq_out(irq_out));

// ==== dv/uart_transmit_format_control_tb.sv ====
module uart_transmit_format_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst, reg_write, reg_read, tx_out, tx_oe, rx_oe_enable, irq_out, stop_ok;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [8:0] rx_word;
  logic [3:0] nbits;
  int frames, bit_clks, error_cnt, compares;
  uart_transmit_format_control uart_transmit_format_control_inst (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .tx_out(tx_out), .tx_oe(tx_oe), .rx_oe_enable(rx_oe_enable),
    .irq_out(irq_out));
  uart_line_rx uart_line_rx_inst (.clk_sys(clk_sys), .tx_out(tx_out), .tx_oe(tx_oe),
    .bit_clks(bit_clks), .nbits(nbits), .rx_word(rx_word), .stop_ok(stop_ok), .frames(frames));
  // 25 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic test_done();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic wait_frames(input int n);
    for (int i = 0; i < 8000 && frames < n; i++) @(posedge clk_sys);
    if (frames < n) begin
      error_cnt++;
      $display("Error at %0t: no frame on the line", $time);
      test_done();
    end
  endtask
  // Expected line word: ninth bit from control, parity in the top position.
  function automatic logic [8:0] exp_word(input logic [7:0] c, input logic [7:0] d);
    logic [8:0] w;
    w = {c[0], d};
    if (c[5] && c[6]) w[8] = ^d ^ c[4];
    if (c[5] && !c[6]) w[7] = ^d[6:0] ^ c[4];
    if (!c[6]) w[8] = 1'b0;
    return w;
  endfunction
  task automatic t_reset();
    rd(3'h0, v);
    chk(v, 8'h00);
    rd(3'h2, v);
    chk(v, 8'h00);
    rd(3'h3, v);
    chk(v[3:0], 4'h7);
    rd(3'h7, v);
    chk(v, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_frame(input logic [7:0] c, c2, dv, d);
    int n0;
    wr(3'h0, c);
    wr(3'h1, c2);
    wr(3'h2, dv);
    bit_clks = (c2[5] ? 16 : 64) * (dv + 1);
    nbits = c[6] ? 4'h9 : 4'h8;
    n0 = frames;
    rd(3'h3, v);
    wr(3'h4, d);
    rd(3'h3, v);
    chk({v[3], v[1], v[0]}, 3'h5);
    wait_frames(n0 + 1);
    chk(rx_word, exp_word(c, d));
    chk(stop_ok, 1'b1);
    repeat (2 * bit_clks) @(posedge clk_sys);
    rd(3'h3, v);
    chk(v[3:0], 4'h7);
    chk({tx_oe, tx_out}, 2'h3);
    $display("frame test done");
  endtask
  // Second byte waits behind the first; a third write while full is dropped.
  task automatic t_b2b();
    int n0;
    wr(3'h0, 8'h80);
    nbits = 4'h8;
    n0 = frames;
    rd(3'h3, v);
    wr(3'h4, 8'h11);
    rd(3'h3, v);
    wr(3'h4, 8'h22);
    rd(3'h3, v);
    chk(v[0], 1'b0);
    wr(3'h4, 8'h44);
    wait_frames(n0 + 1);
    chk(rx_word, 9'h011);
    wait_frames(n0 + 2);
    chk(rx_word, 9'h022);
    repeat (30 * bit_clks) @(posedge clk_sys);
    chk(frames, n0 + 2);
    $display("queue test done");
  endtask
  task automatic t_irq();
    wr(3'h1, 8'hE8);
    repeat (3) @(posedge clk_sys);
    chk(irq_out, 1'b1);
    wr(3'h1, 8'hE0);
    repeat (3) @(posedge clk_sys);
    chk(irq_out, 1'b0);
    $display("irq test done");
  endtask
  // Break cleared mid second chunk must end after 1 + 26 bit times low.
  // The line is sampled 1 ns after each edge so the count sees settled values.
  task automatic t_break();
    int n;
    int lim;
    wr(3'h1, 8'hF0);
    for (lim = 0; tx_out !== 1'b0 && lim < 64; lim++) begin
      @(posedge clk_sys);
      #1;
    end
    n = 0;
    while (tx_out === 1'b0 && n < 1000) begin
      @(posedge clk_sys);
      // The clear is driven right on the edge and held for one full cycle.
      if (n == 320) begin
        reg_addr <= 3'h1;
        reg_wdata <= 8'hE0;
        reg_write <= 1'b1;
      end
      if (n == 321) begin
        reg_write <= 1'b0;
      end
      #1;
      n++;
    end
    if (lim == 64 || n == 1000) begin
      error_cnt++;
      $display("Error at %0t: break never started or never ended", $time);
      test_done();
    end
    chk(n >= 432 && n <= 437, 1'b1);
    chk(tx_oe, 1'b1);
    repeat (4 * bit_clks) @(posedge clk_sys);
    rd(3'h3, v);
    chk(v[1], 1'b1);
    $display("break test done");
  endtask
  task automatic t_abort();
    int n0;
    n0 = frames;
    rd(3'h3, v);
    wr(3'h4, 8'hF0);
    rd(3'h3, v);
    wr(3'h4, 8'h0F);
    repeat (3 * bit_clks) @(posedge clk_sys);
    wr(3'h0, 8'h08);
    repeat (2) @(posedge clk_sys);
    chk({tx_oe, rx_oe_enable}, 2'h0);
    rd(3'h3, v);
    chk(v[1:0], 2'h3);
    rd(3'h1, v);
    chk(v, 8'h20);
    wr(3'h0, 8'h88);
    wr(3'h1, 8'hE0);
    repeat (40 * bit_clks) @(posedge clk_sys);
    chk(frames, n0 + 1);
    rd(3'h3, v);
    wr(3'h4, 8'hF0);
    repeat (3 * bit_clks) @(posedge clk_sys);
    wr(3'h1, 8'h60);
    repeat (2) @(posedge clk_sys);
    chk(tx_oe, 1'b0);
    repeat (12 * bit_clks) @(posedge clk_sys);
    // Data loaded while the transmitter is off must go out once it is switched on.
    n0 = frames;
    rd(3'h3, v);
    wr(3'h4, 8'h69);
    wr(3'h1, 8'hE0);
    wait_frames(n0 + 1);
    chk(rx_word, 9'h069);
    repeat (3 * bit_clks) @(posedge clk_sys);
    $display("abort test done");
  endtask
  initial begin
    rst = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    bit_clks = 16;
    nbits = 4'h8;
    error_cnt = 0;
    compares = 0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_frame(8'h80, 8'h80, 8'h00, 8'hA5);
    t_frame(8'hC9, 8'hE0, 8'h01, 8'h3C);
    t_frame(8'hA0, 8'hE0, 8'h00, 8'h25);
    t_frame(8'hF8, 8'hE0, 8'h00, 8'h5A);
    t_frame(8'hB0, 8'hE0, 8'h00, 8'h3C);
    t_b2b();
    t_irq();
    t_break();
    t_abort();
    t_frame(8'h80, 8'hE0, 8'h00, 8'h96);
    test_done();
  end
endmodule
